// File: src/vlss_top.sv
// output limit, slew rate and divider ratio command registers
`timescale 1ns/1ps
`default_nettype none
`include "vlss_regs.svh"
module vlss_top #(
  parameter int TARGET_W = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // decoded command transactions from the bus engine
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_wdata,
  // command answers
  output logic resp_valid,
  output logic resp_nack,
  output logic [15:0] resp_rdata,
  // configuration strap and regulator state
  input wire logic loop_slave_strap,
  input wire logic output_on,
  input wire vlss_pkg::vlss_phase_t ramp_phase,
  // other contributors to the effective target
  input wire logic [11:0] lower_limit,
  input wire logic signed [15:0] ref_trim,
  input wire logic signed [15:0] margin_high_step,
  input wire logic signed [15:0] margin_low_step,
  input wire logic margin_high_en,
  input wire logic margin_low_en,
  input wire logic target_input_chg,
  input wire logic lower_limit_wr,
  // ramp rate selection
  input wire vlss_pkg::vlss_rate_sel_t soft_start_ramp,
  input wire vlss_pkg::vlss_rate_sel_t turn_off_ramp,
  output vlss_pkg::vlss_rate_sel_t ramp_rate_sel,
  // reference to the regulation loop, quarter counts of 2^-9 V
  output logic signed [TARGET_W-1:0] reference_q,
  output logic ref_clamped,
  // status event pulses
  output logic misc_fault_flag_set,
  output logic output_warning_flag_set,
  output logic limit_warning_set,
  output logic cml_flag_set,
  output logic invalid_data_set,
  output logic invalid_command_flag_set,
  output logic alert_req,
  // nonvolatile storage
  input wire logic store_all,
  input wire logic nvm_load,
  input wire logic [2:0] nvm_rd_data,
  output logic nvm_wr_en,
  output logic [2:0] nvm_wr_data
);

  // limit times ratio plus shifted margins needs at least 18 bits
  if (TARGET_W < 18 || TARGET_W > 32) begin : g_width_check
    $error("vlss_top: TARGET_W must lie in 18..32");
  end

  logic [11:0] setpoint_r;
  logic [11:0] upper_r;
  logic [6:0] slew_r;
  logic [2:0] ratio_r;
  logic loop_slave_r;
  logic strap_done_r;
  logic recalc_r;
  logic [11:0] ul_lo;
  logic [11:0] ul_hi;
  logic [2:0] slew_sel;

  // command decode
  logic hit_sp, hit_ul, hit_sr, hit_dr, hit;
  logic wr_sp, wr_ul, wr_sr, wr_dr;
  logic refuse;
  logic sp_bad, ul_bad, dr_bad, bad_data;
  logic [2:0] dr_mant;

  assign hit_sp = cmd_code == `VLSS_OFS_SETPOINT;
  assign hit_ul = cmd_code == `VLSS_OFS_UPPER_LIMIT;
  assign hit_sr = cmd_code == `VLSS_OFS_SLEW_RATE;
  assign hit_dr = cmd_code == `VLSS_OFS_DIV_RATIO;
  assign hit = cmd_valid && (hit_sp || hit_ul || hit_sr || hit_dr);
  assign refuse = hit && loop_slave_r;

  assign sp_bad = cmd_wdata[11:0] > `VLSS_SETPOINT_MAX;
  // limit window follows the ratio held right now
  assign ul_bad = cmd_wdata[11:0] < ul_lo || cmd_wdata[11:0] > ul_hi;

  always_comb begin
    dr_bad = 1'b0;
    dr_mant = `VLSS_RMANT_ONE;
    unique case (cmd_wdata)
      `VLSS_RATIO_ONE: dr_mant = `VLSS_RMANT_ONE;
      `VLSS_RATIO_HALF: dr_mant = `VLSS_RMANT_HALF;
      `VLSS_RATIO_QUARTER: dr_mant = `VLSS_RMANT_QUARTER;
      default: dr_bad = 1'b1;
    endcase
  end

  // refused or malformed words never reach a register
  assign wr_sp = hit_sp && cmd_valid && cmd_write && !refuse && !sp_bad;
  assign wr_ul = hit_ul && cmd_valid && cmd_write && !refuse && !ul_bad;
  assign wr_sr = hit_sr && cmd_valid && cmd_write && !refuse;
  assign wr_dr = hit_dr && cmd_valid && cmd_write && !refuse && !dr_bad;
  assign bad_data = hit && cmd_write && !refuse &&
                    ((hit_sp && sp_bad) || (hit_ul && ul_bad) ||
                     (hit_dr && dr_bad));

  vlss_limit_range u_range (
    .ratio_mant(ratio_r),
    .lo(ul_lo),
    .hi(ul_hi)
  );

  vlss_slew_map u_slew (
    .mant(slew_r),
    .sel(slew_sel)
  );

  // strap is caught on the first edge after release, not under reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  // held for the whole run so a late strap glitch cannot flip the role
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loop_slave_r <= 1'b0;
    end else if (!strap_done_r) begin
      loop_slave_r <= loop_slave_strap;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      setpoint_r <= 12'(`VLSS_SETPOINT_RST);
    end else if (wr_sp) begin
      setpoint_r <= cmd_wdata[11:0];
    end
  end

  // only the mantissa is stored; the exponent is a constant on read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      upper_r <= 12'(`VLSS_UPPER_RST);
    end else if (wr_ul) begin
      upper_r <= cmd_wdata[11:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slew_r <= 7'(`VLSS_SLEW_RST);
    end else if (wr_sr) begin
      slew_r <= cmd_wdata[6:0];
    end
  end

  // only the slave role gates a ratio write, not a load from storage; otherwise only the value is checked
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ratio_r <= 3'(`VLSS_RATIO_RST);
    end else if (wr_dr) begin
      ratio_r <= dr_mant;
    end else if (nvm_load && (nvm_rd_data == `VLSS_RMANT_ONE ||
                              nvm_rd_data == `VLSS_RMANT_HALF ||
                              nvm_rd_data == `VLSS_RMANT_QUARTER)) begin
      ratio_r <= nvm_rd_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nvm_wr_en <= 1'b0;
    end else begin
      nvm_wr_en <= store_all;
    end
  end

  // snapshot taken with the strobe so storage sees one stable word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nvm_wr_data <= 3'h0;
    end else if (store_all) begin
      nvm_wr_data <= ratio_r;
    end
  end

  // command answers, one cycle after the request
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (hit_sp) rd_word = {4'h0, setpoint_r};
    else if (hit_ul) rd_word = {4'h0, upper_r};
    else if (hit_sr) rd_word = {`VLSS_SLEW_EXP, 4'h0, slew_r};
    else if (hit_dr) rd_word = {`VLSS_RATIO_EXP, 8'h00, ratio_r};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_nack <= 1'b0;
    end else begin
      resp_valid <= hit;
      resp_nack <= refuse || bad_data;
    end
  end

  // read data holds until the next answer so a slow host can still take it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resp_rdata <= 16'h0000;
    end else if (hit && !cmd_write && !refuse) begin
      resp_rdata <= rd_word;
    end else if (hit) begin
      resp_rdata <= 16'h0000;
    end
  end

  // effective target and clamp, in quarter counts
  logic signed [TARGET_W-1:0] target_q;
  logic signed [TARGET_W-1:0] max_q;
  logic signed [TARGET_W-1:0] adj;
  logic conflict, overrun, violation;

  // operands widened before the product so no carry is lost
  logic signed [TARGET_W-1:0] sp_w;
  logic signed [TARGET_W-1:0] ul_w;
  logic signed [TARGET_W-1:0] ratio_w;
  assign sp_w = $signed(TARGET_W'(setpoint_r));
  assign ul_w = $signed(TARGET_W'(upper_r));
  assign ratio_w = $signed(TARGET_W'(ratio_r));

  always_comb begin
    adj = TARGET_W'(ref_trim);
    if (margin_high_en) adj = adj + TARGET_W'(margin_high_step);
    if (margin_low_en) adj = adj + TARGET_W'(margin_low_step);
    target_q = sp_w * ratio_w + (adj <<< 2);
    max_q = ul_w * ratio_w;
  end

  // equal limits count as a conflict too
  assign conflict = upper_r <= lower_limit;
  assign overrun = target_q > max_q;
  assign violation = output_on && (conflict || overrun);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      recalc_r <= 1'b0;
    end else begin
      recalc_r <= wr_sp || wr_ul || wr_dr || lower_limit_wr ||
                  target_input_chg;
    end
  end

  // upper limit wins over the lower limit when they conflict
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reference_q <= '0;
    end else if (violation) begin
      reference_q <= max_q;
    end else begin
      reference_q <= target_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ref_clamped <= 1'b0;
    end else begin
      ref_clamped <= violation;
    end
  end

  // warnings only on a change that lands in violation, not every cycle
  logic warn_ev;
  assign warn_ev = recalc_r && violation;

  // limit warnings, one pulse per offending change
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      misc_fault_flag_set <= 1'b0;
      output_warning_flag_set <= 1'b0;
      limit_warning_set <= 1'b0;
    end else begin
      misc_fault_flag_set <= warn_ev;
      output_warning_flag_set <= warn_ev;
      limit_warning_set <= warn_ev;
    end
  end

  // command faults, aligned with the refused answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cml_flag_set <= 1'b0;
      invalid_data_set <= 1'b0;
      invalid_command_flag_set <= 1'b0;
    end else begin
      cml_flag_set <= bad_data;
      invalid_data_set <= bad_data;
      invalid_command_flag_set <= refuse;
    end
  end

  // alert merges every source; masking is done by the status block
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alert_req <= 1'b0;
    end else begin
      alert_req <= warn_ev || bad_data || refuse;
    end
  end

  // the slew setting covers normal moves and the off-delay state only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ramp_rate_sel <= 3'h0;
    end else begin
      unique case (ramp_phase)
        vlss_pkg::VLSS_PH_NORMAL: ramp_rate_sel <= slew_sel;
        vlss_pkg::VLSS_PH_OFF_DELAY: ramp_rate_sel <= slew_sel;
        vlss_pkg::VLSS_PH_SOFT_START: ramp_rate_sel <= soft_start_ramp;
        vlss_pkg::VLSS_PH_TURN_OFF: ramp_rate_sel <= turn_off_ramp;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: src/vlss_regs.svh
// register offsets, field layouts, reset values and ranges for the vlss block
`ifndef VLSS_REGS_SVH
`define VLSS_REGS_SVH

// command codes
`define VLSS_OFS_SETPOINT     8'h21
`define VLSS_OFS_UPPER_LIMIT  8'h24
`define VLSS_OFS_SLEW_RATE    8'h27
`define VLSS_OFS_DIV_RATIO    8'h29

// field layout
`define VLSS_LIM_MANT_W       12
`define VLSS_SLEW_MANT_W      7
`define VLSS_RATIO_MANT_W     3
`define VLSS_EXP_MSB          15
`define VLSS_EXP_LSB          11

// fixed exponents
`define VLSS_VOUT_EXP         5'h17
`define VLSS_SLEW_EXP         5'h1A
`define VLSS_RATIO_EXP        5'h1E

// reset values
`define VLSS_SETPOINT_RST     16'h0133
`define VLSS_UPPER_RST        16'h034D
`define VLSS_SLEW_RST         16'hD03C
`define VLSS_RATIO_RST        16'hF004

// legal divider words and mantissas
`define VLSS_RATIO_ONE        16'hF004
`define VLSS_RATIO_HALF       16'hF002
`define VLSS_RATIO_QUARTER    16'hF001
`define VLSS_RMANT_ONE        3'h4
`define VLSS_RMANT_HALF       3'h2
`define VLSS_RMANT_QUARTER    3'h1

// upper limit valid ranges per ratio
`define VLSS_UL_MIN_ONE       12'h11A
`define VLSS_UL_MAX_ONE       12'h34D
`define VLSS_UL_MIN_HALF      12'h234
`define VLSS_UL_MAX_HALF      12'h69A
`define VLSS_UL_MIN_QUARTER   12'h468
`define VLSS_UL_MAX_QUARTER   12'hC00

// setpoint ceiling, invalid above
`define VLSS_SETPOINT_MAX     12'hB00

// slew bucket upper bounds
`define VLSS_SLEW_B0          7'h05
`define VLSS_SLEW_B1          7'h07
`define VLSS_SLEW_B2          7'h0C
`define VLSS_SLEW_B3          7'h11
`define VLSS_SLEW_B4          7'h19
`define VLSS_SLEW_B5          7'h2F
`define VLSS_SLEW_B6          7'h4F

`endif

// File: src/vlss_pkg.sv
// types shared by the vlss block
package vlss_pkg;
  typedef enum logic [1:0] {
    VLSS_PH_NORMAL,
    VLSS_PH_SOFT_START,
    VLSS_PH_OFF_DELAY,
    VLSS_PH_TURN_OFF
  } vlss_phase_t;
  typedef logic [2:0] vlss_rate_sel_t;
endpackage

// File: src/vlss_slew_map.sv
// maps a slew mantissa onto one of eight fixed ramp rates
`timescale 1ns/1ps
`default_nettype none
`include "vlss_regs.svh"
module vlss_slew_map (
  // programmed mantissa
  input wire logic [6:0] mant,
  // selected bucket, 0 = slowest
  output logic [2:0] sel
);
  always_comb begin
    if (mant <= `VLSS_SLEW_B0) sel = 3'h0;
    else if (mant <= `VLSS_SLEW_B1) sel = 3'h1;
    else if (mant <= `VLSS_SLEW_B2) sel = 3'h2;
    else if (mant <= `VLSS_SLEW_B3) sel = 3'h3;
    else if (mant <= `VLSS_SLEW_B4) sel = 3'h4;
    else if (mant <= `VLSS_SLEW_B5) sel = 3'h5;
    else if (mant <= `VLSS_SLEW_B6) sel = 3'h6;
    else sel = 3'h7;
  end
endmodule
`default_nettype wire

// File: src/vlss_limit_range.sv
// valid upper-limit mantissa window for the divider ratio in force
`timescale 1ns/1ps
`default_nettype none
`include "vlss_regs.svh"
module vlss_limit_range (
  // divider mantissa
  input wire logic [2:0] ratio_mant,
  // window bounds
  output logic [11:0] lo,
  output logic [11:0] hi
);
  always_comb begin
    if (ratio_mant == `VLSS_RMANT_HALF) begin
      lo = `VLSS_UL_MIN_HALF;
      hi = `VLSS_UL_MAX_HALF;
    end else if (ratio_mant == `VLSS_RMANT_QUARTER) begin
      lo = `VLSS_UL_MIN_QUARTER;
      hi = `VLSS_UL_MAX_QUARTER;
    end else begin
      lo = `VLSS_UL_MIN_ONE;
      hi = `VLSS_UL_MAX_ONE;
    end
  end
endmodule
`default_nettype wire

// File: tb/vlss_host_model.sv
// host model issuing one command word per call
`timescale 1ns/1ps
`default_nettype none
module vlss_host_model (
  // clock
  input wire logic clk_sys,
  // request
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic cmd_write,
  output logic [15:0] cmd_wdata,
  // answer
  input wire logic resp_valid,
  input wire logic resp_nack,
  input wire logic [15:0] resp_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_write = 1'b0;
    cmd_wdata = 16'h0000;
  end
  task automatic xfer(input logic [7:0] c, input logic w,
    input logic [15:0] d, output logic n, output logic [15:0] q);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_write = w;
    cmd_wdata = d;
    @(negedge clk_sys);
    // answer stands for one cycle after the taking edge; no answer is x
    n = resp_valid ? resp_nack : 1'bx;
    q = resp_rdata;
    cmd_valid = 1'b0;
    // released lines must not keep the last word
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// File: tb/vlss_top_asserts.sv
// concurrent checks on the vlss command register ports
`timescale 1ns/1ps
`default_nettype none
module vlss_top_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_wdata,
  input wire logic resp_valid,
  input wire logic resp_nack,
  input wire logic [15:0] resp_rdata,
  // ramp
  input wire vlss_pkg::vlss_phase_t ramp_phase,
  input wire vlss_pkg::vlss_rate_sel_t soft_start_ramp,
  input wire vlss_pkg::vlss_rate_sel_t ramp_rate_sel,
  // status and storage
  input wire logic ref_clamped,
  input wire logic misc_fault_flag_set,
  input wire logic output_warning_flag_set,
  input wire logic limit_warning_set,
  input wire logic cml_flag_set,
  input wire logic invalid_data_set,
  input wire logic invalid_command_flag_set,
  input wire logic alert_req,
  input wire logic store_all,
  input wire logic nvm_wr_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_resp_next_cycle: assert property (cmd_valid && cmd_code inside
    {8'h21, 8'h24, 8'h27, 8'h29} |=> resp_valid) else $error("no answer");
  chk_slew_exp_fixed: assert property (resp_valid && !resp_nack &&
    $past(!cmd_write && cmd_code == 8'h27) |-> resp_rdata[15:7] == 9'h1A0)
    else $error("slew exponent not fixed");
  chk_ratio_word_legal: assert property (resp_valid && !resp_nack &&
    $past(!cmd_write && cmd_code == 8'h29) |->
    resp_rdata inside {16'hF004, 16'hF002, 16'hF001})
    else $error("illegal divider word read");
  chk_limit_exp_zero: assert property (resp_valid && !resp_nack &&
    $past(!cmd_write && cmd_code == 8'h24) |-> resp_rdata[15:12] == 4'h0)
    else $error("upper limit high bits set");
  chk_read_refused: assert property (resp_valid && resp_nack &&
    !$past(cmd_write) |-> invalid_command_flag_set && alert_req)
    else $error("refused read without flags");
  chk_bad_ratio_nack: assert property (resp_valid && $past(cmd_write &&
    cmd_code == 8'h29 && !(cmd_wdata inside {16'hF004, 16'hF002, 16'hF001}))
    |-> resp_nack && alert_req && (invalid_command_flag_set ||
    cml_flag_set && invalid_data_set)) else $error("bad ratio accepted");
  chk_warn_flags_set: assert property (misc_fault_flag_set |->
    output_warning_flag_set && limit_warning_set && alert_req && ref_clamped)
    else $error("limit warning set incomplete");
  chk_nvm_store_pulse: assert property (store_all |=> nvm_wr_en)
    else $error("store not written");
  chk_soft_ramp_sel: assert property ($past(rst_n) &&
    $past(ramp_phase) == vlss_pkg::VLSS_PH_SOFT_START |->
    ramp_rate_sel == $past(soft_start_ramp)) else $error("soft ramp wrong");
endmodule
bind vlss_top vlss_top_asserts u_chk (.clk_sys, .rst_n, .cmd_valid,
  .cmd_code, .cmd_write, .cmd_wdata, .resp_valid, .resp_nack, .resp_rdata,
  .ramp_phase, .soft_start_ramp, .ramp_rate_sel, .ref_clamped,
  .misc_fault_flag_set, .output_warning_flag_set, .limit_warning_set,
  .cml_flag_set, .invalid_data_set, .invalid_command_flag_set, .alert_req,
  .store_all, .nvm_wr_en);
`default_nettype wire

// File: tb/vlss_top_test.sv
// self-checking bench for the vlss command registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module vlss_top_test;
  logic clk_sys = 1'b0;
  logic rst_n, cmd_valid, cmd_write, resp_valid, resp_nack, output_on;
  logic loop_slave_strap, margin_high_en, target_input_chg, lower_limit_wr;
  logic ref_clamped, misc_fault_flag_set, output_warning_flag_set, nk;
  logic limit_warning_set, cml_flag_set, invalid_data_set, alert_req;
  logic invalid_command_flag_set, store_all, nvm_load, nvm_wr_en;
  logic mf_seen, icf_seen, ivd_seen;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, resp_rdata, rd, d;
  logic [11:0] lower_limit, v;
  logic signed [15:0] margin_high_step;
  logic [2:0] nvm_rd_data, nvm_wr_data;
  logic signed [19:0] reference_q;
  vlss_pkg::vlss_phase_t ramp_phase;
  vlss_pkg::vlss_rate_sel_t soft_start_ramp, turn_off_ramp, ramp_rate_sel, e;
  int error_cnt, samples_checked, cyc;
  logic [7:0] codes [4] = '{8'h21, 8'h24, 8'h27, 8'h29};
  logic [15:0] rst_v [4] = '{16'h0133, 16'h034D, 16'hD03C, 16'hF004};
  logic [15:0] rw [3] = '{16'hF002, 16'hF001, 16'hF004};
  logic [11:0] lo [3] = '{12'h234, 12'h468, 12'h11A};
  logic [11:0] hi [3] = '{12'h69A, 12'hC00, 12'h34D};
  logic [6:0] corn [16] = '{7'h05, 7'h06, 7'h07, 7'h08, 7'h0C, 7'h0D,
    7'h11, 7'h12, 7'h19, 7'h1A, 7'h2F, 7'h30, 7'h4F, 7'h50, 7'h00, 7'h7F};
  vlss_top DUT (.clk_sys, .rst_n, .cmd_valid, .cmd_code, .cmd_write,
    .cmd_wdata, .resp_valid, .resp_nack, .resp_rdata, .loop_slave_strap,
    .output_on, .ramp_phase, .lower_limit, .ref_trim(16'sh0000),
    .margin_high_step, .margin_low_step(16'sh0000), .margin_high_en,
    .margin_low_en(1'b0), .target_input_chg, .lower_limit_wr,
    .soft_start_ramp, .turn_off_ramp, .ramp_rate_sel, .reference_q,
    .ref_clamped, .misc_fault_flag_set, .output_warning_flag_set,
    .limit_warning_set, .cml_flag_set, .invalid_data_set,
    .invalid_command_flag_set, .alert_req, .store_all, .nvm_load,
    .nvm_rd_data, .nvm_wr_en, .nvm_wr_data);
  vlss_host_model hm (.clk_sys, .cmd_valid, .cmd_code, .cmd_write,
    .cmd_wdata, .resp_valid, .resp_nack, .resp_rdata);
  always #2.5 clk_sys = ~clk_sys;
  function automatic logic [2:0] bucket(input logic [6:0] m);
    logic [6:0] b [7] = '{7'h05, 7'h07, 7'h0C, 7'h11, 7'h19, 7'h2F, 7'h4F};
    bucket = 3'h7;
    for (int i = 6; i >= 0; i--) if (m <= b[i]) bucket = 3'(i);
  endfunction
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    @(negedge clk_sys);
    rst_n = 1'b0;
    loop_slave_strap = s;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (misc_fault_flag_set) mf_seen <= 1'b1;
    if (invalid_command_flag_set) icf_seen <= 1'b1;
    if (invalid_data_set) ivd_seen <= 1'b1;
    // whole run needs well under a thousand cycles
    if (cyc == 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, output_on, margin_high_en, target_input_chg} = 4'h0;
    {lower_limit_wr, store_all, nvm_load, loop_slave_strap} = 4'h0;
    {mf_seen, icf_seen, ivd_seen} = 3'h0;
    lower_limit = 12'h000;
    margin_high_step = 16'sh0000;
    nvm_rd_data = 3'h0;
    ramp_phase = vlss_pkg::VLSS_PH_NORMAL;
    void'($urandom(32'hE411));
    soft_start_ramp = 3'($urandom);
    turn_off_ramp = 3'($urandom);
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      hm.xfer(codes[i], 1'b0, 16'h0000, nk, rd);
      `CHK(rd, rst_v[i])
    end
    for (int i = 0; i < 40; i++) begin
      d = (i < 16) ? {9'h000, corn[i]} : 16'($urandom);
      hm.xfer(8'h27, 1'b1, d, nk, rd);
      `CHK(nk, 1'b0)
      hm.xfer(8'h27, 1'b0, 16'h0000, nk, rd);
      `CHK(rd, {5'h1A, 4'h0, d[6:0]})
      `CHK(ramp_rate_sel, bucket(d[6:0]))
    end
    for (int p = 1; p < 4; p++) begin
      ramp_phase = vlss_pkg::vlss_phase_t'(p);
      repeat (2) @(negedge clk_sys);
      e = p == 1 ? soft_start_ramp : p == 3 ? turn_off_ramp : bucket(d[6:0]);
      `CHK(ramp_rate_sel, e)
    end
    ramp_phase = vlss_pkg::VLSS_PH_NORMAL;
    hm.xfer(8'h29, 1'b1, 16'hF003, nk, rd);
    hm.xfer(8'h29, 1'b0, 16'h0000, nk, rd);
    `CHK({ivd_seen, rd}, {1'b1, 16'hF004})
    for (int r = 0; r < 3; r++) begin
      hm.xfer(8'h29, 1'b1, rw[r], nk, rd);
      `CHK(nk, 1'b0)
      for (int k = 0; k < 4; k++) begin
        v = (k > 1 ? hi[r] : lo[r]) + 12'(k == 3) - 12'(k == 0);
        hm.xfer(8'h24, 1'b1, {4'h0, v}, nk, rd);
        `CHK(nk, k == 0 || k == 3)
      end
      hm.xfer(8'h24, 1'b0, 16'h0000, nk, rd);
      `CHK(rd, {4'h0, hi[r]})
    end
    output_on = 1'b1;
    hm.xfer(8'h21, 1'b1, 16'h0300, nk, rd);
    repeat (2) @(negedge clk_sys);
    `CHK(reference_q, 20'sh00C00)
    mf_seen = 1'b0;
    hm.xfer(8'h24, 1'b1, 16'h0200, nk, rd);
    repeat (2) @(negedge clk_sys);
    `CHK({reference_q, ref_clamped, mf_seen}, {20'sh00800, 2'h3})
    hm.xfer(8'h24, 1'b1, 16'h0300, nk, rd);
    lower_limit = 12'h310;
    mf_seen = 1'b0;
    pulse(lower_limit_wr);
    repeat (3) @(negedge clk_sys);
    `CHK({reference_q, ref_clamped, mf_seen}, {20'sh00C00, 2'h3})
    lower_limit = 12'h000;
    margin_high_en = 1'b1;
    margin_high_step = 16'sh0064;
    mf_seen = 1'b0;
    pulse(target_input_chg);
    repeat (3) @(negedge clk_sys);
    `CHK({reference_q, mf_seen}, {20'sh00C00, 1'b1})
    pulse(store_all);
    `CHK({nvm_wr_en, nvm_wr_data}, 4'hC)
    for (int i = 0; i < 2; i++) begin
      nvm_rd_data = i == 0 ? 3'h1 : 3'h3;
      pulse(nvm_load);
      hm.xfer(8'h29, 1'b0, 16'h0000, nk, rd);
      `CHK(rd, 16'hF001)
    end
    do_reset(1'b1);
    hm.xfer(8'h24, 1'b0, 16'h0000, nk, rd);
    @(negedge clk_sys);
    `CHK({nk, icf_seen}, 2'h3)
    hm.xfer(8'h27, 1'b1, 16'h0005, nk, rd);
    `CHK(nk, 1'b1)
    report_and_stop();
  end
endmodule
`default_nettype wire
